/* inc/ca_parity_pkg.sv */
/*
  Constants for the command/address parity checker and clock gate.
  Assumes one 125 MHz sampling clock and pins sampled through synchronisers.
*/
package ca_parity_pkg;
  localparam int ADDR_W = 16;
  localparam int BANK_W = 3;
  localparam int CS_W = 4;
  // Addr, bank and three command strobes
  localparam int CA_W = 22;
  // Positions in the synchronised pin vector
  localparam int POS_ADDR = 0;
  localparam int POS_BANK = 16;
  localparam int POS_WE = 19;
  localparam int POS_CAS = 20;
  localparam int POS_RAS = 21;
  localparam int POS_PAR = 22;
  localparam int POS_CS = 23;
  localparam int POS_CKP = 27;
  localparam int POS_CKN = 28;
  localparam int POS_QUAD_N = 29;
  localparam int POS_SUPPLY = 30;
  localparam int PIN_W = 31;
  localparam int NUM_CLK_PAIRS = 4;
  // Error output low time in link clock cycles, counted down from here
  localparam int ERR_HOLD_CYCLES = 2;
  localparam logic [1:0] ERR_HOLD_INIT = 2'h1;
  localparam logic [1:0] ERR_HOLD_DONE = 2'h0;
  localparam logic [PIN_W-1:0] PIN_RESET = 31'h0000_0000;
endpackage

/* verilog/pin_sync.sv */
/*
  Three-stage synchroniser with agreement filter for a group of pins.
  Assumes pins are asynchronous to mclk; rst is synchronous, active high.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once the last two stages agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      dout <= '0;
    end else begin
      dout <= (s2_q & s3_q) | (dout & (s2_q ^ s3_q));
    end
  end
endmodule
`default_nettype wire

/* verilog/ca_parity_check_and_clock_gate.sv */
/*
  Command/address even-parity checker with open-drain error output,
  buffered clock gating and PLL bypass status.
  Assumes the link clock pair and all pins are sampled by mclk, far faster
  than the link clock; the control logic drives clock_out_disable.
*/
`timescale 1ns/10ps
`default_nettype none
module ca_parity_check_and_clock_gate (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ck_p,
  input wire logic ck_n,
  input wire logic [ca_parity_pkg::ADDR_W-1:0] row_col_addr_in,
  input wire logic [ca_parity_pkg::BANK_W-1:0] bank_addr_in,
  input wire logic row_strobe_in,
  input wire logic column_strobe_in,
  input wire logic write_strobe_in,
  input wire logic parity_bit_in,
  input wire logic [ca_parity_pkg::CS_W-1:0] chip_select_in_quad,
  input wire logic quad_cs_enable_n,
  input wire logic pll_analog_supply,
  input wire logic clock_out_disable,
  output logic parity_error_n_out,
  output logic parity_error_n_oe_n,
  output logic [ca_parity_pkg::NUM_CLK_PAIRS-1:0] buffered_clock_out_p,
  output logic [ca_parity_pkg::NUM_CLK_PAIRS-1:0] buffered_clock_out_n,
  output logic [ca_parity_pkg::NUM_CLK_PAIRS-1:0] buffered_clock_oe_n,
  output logic feedback_clock_out_p,
  output logic feedback_clock_out_n,
  output logic feedback_clock_oe_n,
  output logic pll_on_q,
  output logic pll_bypass_q
);
  import ca_parity_pkg::*;

  function automatic logic odd_ones(input logic [CA_W-1:0] v);
    odd_ones = ^v;
  endfunction

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_f;
  logic [CA_W-1:0] ca_word;
  logic [CS_W-1:0] cs_f;
  logic ckp_f;
  logic ckn_f;
  logic par_f;
  logic quad_f;
  logic supply_f;
  logic standby;
  logic ck_hi;
  logic ck_hi_q;
  logic ck_rise;
  logic sel;
  logic word_sel_q;
  logic word_par_q;
  logic st1_err_q;
  logic st2_err_q;
  logic [1:0] hold_q;
  logic [1:0] low_rises_q;

  assign pins_raw = {pll_analog_supply, quad_cs_enable_n, ck_n, ck_p,
    chip_select_in_quad, parity_bit_in, row_strobe_in, column_strobe_in,
    write_strobe_in, bank_addr_in, row_col_addr_in};

  pin_sync #(
    .W(PIN_W)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din(pins_raw),
    .dout(pins_f)
  );

  // CKE, ODT and selects never enter the sum
  assign ca_word = pins_f[POS_RAS:POS_ADDR];
  assign cs_f = pins_f[POS_CS+CS_W-1:POS_CS];
  assign ckp_f = pins_f[POS_CKP];
  assign ckn_f = pins_f[POS_CKN];
  assign par_f = pins_f[POS_PAR];
  assign quad_f = ~pins_f[POS_QUAD_N];
  assign supply_f = pins_f[POS_SUPPLY];
  assign standby = ~ckp_f & ~ckn_f;
  assign ck_hi = ckp_f & ~ckn_f;
  assign ck_rise = ck_hi & ~ck_hi_q;
  // Two-select mode looks at the low pair only
  assign sel = quad_f ? ~&cs_f : ~&cs_f[1:0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      ck_hi_q <= 1'b0;
    end else begin
      ck_hi_q <= ck_hi;
    end
  end

  // Stage 0: word registered at the clock crossing
  always_ff @(posedge mclk) begin
    if (rst || standby) begin
      word_sel_q <= 1'b0;
      word_par_q <= 1'b0;
    end else if (ck_rise) begin
      word_sel_q <= sel;
      word_par_q <= odd_ones(ca_word);
    end
  end

  // Stage 1: parity bit trails its word by one clock
  always_ff @(posedge mclk) begin
    if (rst || standby) begin
      st1_err_q <= 1'b0;
    end else if (ck_rise) begin
      st1_err_q <= word_sel_q & (word_par_q ^ par_f);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || standby) begin
      st2_err_q <= 1'b0;
    end else if (ck_rise) begin
      st2_err_q <= st1_err_q;
    end
  end

  // Stage 3: open-drain error, pulled low only by the enable
  always_ff @(posedge mclk) begin
    if (rst || standby) begin
      parity_error_n_oe_n <= 1'b1;
      hold_q <= ERR_HOLD_DONE;
    end else if (ck_rise) begin
      if (!parity_error_n_oe_n) begin
        // Results met while low are dropped, not queued
        if (hold_q == ERR_HOLD_DONE) begin
          parity_error_n_oe_n <= 1'b1;
        end else begin
          hold_q <= hold_q - 2'h1;
        end
      end else if (st2_err_q) begin
        parity_error_n_oe_n <= 1'b0;
        hold_q <= ERR_HOLD_INIT;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      parity_error_n_out <= 1'b0;
    end else begin
      parity_error_n_out <= 1'b0;
    end
  end

  // Clock pairs follow the sampled input; clock_out_disable gates the buffered pairs, feedback enable is internal
  always_ff @(posedge mclk) begin
    if (rst || standby) begin
      buffered_clock_out_p <= '0;
      buffered_clock_out_n <= '1;
      buffered_clock_oe_n <= '1;
      feedback_clock_out_p <= 1'b0;
      feedback_clock_out_n <= 1'b1;
      feedback_clock_oe_n <= 1'b1;
    end else begin
      buffered_clock_out_p <= {NUM_CLK_PAIRS{ckp_f}};
      buffered_clock_out_n <= {NUM_CLK_PAIRS{ckn_f}};
      buffered_clock_oe_n <= {NUM_CLK_PAIRS{clock_out_disable}};
      feedback_clock_out_p <= ckp_f;
      feedback_clock_out_n <= ckn_f;
      feedback_clock_oe_n <= 1'b0;
    end
  end

  // Bypass passes the clock unchanged; timing is not guaranteed then
  always_ff @(posedge mclk) begin
    if (rst || standby) begin
      pll_on_q <= 1'b0;
      pll_bypass_q <= 1'b0;
    end else begin
      pll_on_q <= supply_f;
      pll_bypass_q <= ~supply_f;
    end
  end

  // Helper: link clocks seen while the error is low
  always_ff @(posedge mclk) begin
    if (rst || parity_error_n_oe_n) begin
      low_rises_q <= 2'h0;
    end else if (ck_rise) begin
      low_rises_q <= low_rises_q + 2'h1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_parity_odd_flag: assert property (
    ck_rise && !standby && word_sel_q && (word_par_q != par_f)
    |=> st1_err_q)
    else $error("odd parity sum not flagged");

  a_parity_sum_set: assert property (
    ck_rise && !standby |=> word_par_q == ^$past(ca_word))
    else $error("parity sum covers wrong inputs");

  a_quad_cs_check: assert property (
    ck_rise && !standby && quad_f && (cs_f != 4'hf) && (cs_f[1:0] == 2'h3)
    |=> word_sel_q)
    else $error("quad select word not checked");

  a_error_latency: assert property (
    ck_rise && !standby && st2_err_q && parity_error_n_oe_n
    |=> !parity_error_n_oe_n && hold_q == ERR_HOLD_INIT)
    else $error("error not driven three clocks after word");

  a_error_hold_two: assert property (
    $rose(parity_error_n_oe_n) && !$past(standby) && !$past(rst)
    |-> low_rises_q == 2'h2)
    else $error("error low time is not two clocks");

  a_deselect_clean: assert property (
    ck_rise && !standby && !word_sel_q |=> !st1_err_q)
    else $error("deselected word reported an error");

  a_clock_gate_mode: assert property (
    !standby && clock_out_disable |=> buffered_clock_oe_n == 4'hf
    && !feedback_clock_oe_n && feedback_clock_out_p == $past(ckp_f))
    else $error("clock gating does not match mode bit");

  a_pll_bypass_test: assert property (
    !standby && !supply_f |=> pll_bypass_q && !pll_on_q)
    else $error("grounded supply did not bypass pll");

  a_standby_float: assert property (
    standby |=> parity_error_n_oe_n && feedback_clock_oe_n
    && buffered_clock_oe_n == 4'hf && !pll_on_q)
    else $error("stopped clock did not float outputs");

  c_error_pulse: cover property ($fell(parity_error_n_oe_n));
  c_quad_check: cover property (ck_rise && quad_f && cs_f == 4'hb);
  c_pll_bypass: cover property ($rose(pll_bypass_q));
  c_standby_entry: cover property ($rose(standby));
endmodule
`default_nettype wire

/* verif/ca_controller_model.sv */
/*
  Controller model: link clock pair, command/address words and parity.
  Assumes words arrive from the bench before each falling half.
*/
`timescale 1ns/10ps
`default_nettype none
module ca_controller_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic go,
  input wire logic err_n,
  input wire logic cor,
  input wire logic [25:0] w,
  output logic ck_p,
  output logic ck_n,
  output logic [25:0] word_o,
  output logic par_o,
  output logic rise_s
);
  logic [3:0] ph_q;
  logic stop_q;
  logic cor_q;
  // Half period of 8 mclk keeps the synchroniser comfortable
  always_ff @(posedge mclk) begin
    rise_s <= 1'b0;
    if (rst) begin
      ph_q <= 4'h0;
      stop_q <= 1'b1;
      ck_p <= 1'b0;
      ck_n <= 1'b0;
    end else if (stop_q) begin
      if (go) begin
        stop_q <= 1'b0;
        ck_n <= 1'b1;
        ph_q <= 4'h8;
      end
    end else begin
      ph_q <= ph_q + 4'h1;
      if (ph_q == 4'hf) begin
        ck_p <= 1'b1;
        ck_n <= 1'b0;
        rise_s <= 1'b1;
      end
      if (ph_q == 4'h7) begin
        ck_p <= 1'b0;
        // Standby waits while the error line is pulled low
        ck_n <= go | !err_n;
        stop_q <= !go & err_n;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      word_o <= 26'h0;
      par_o <= 1'b0;
      cor_q <= 1'b0;
    end else if (!stop_q && ph_q == 4'h7) begin
      word_o <= w;
      cor_q <= cor;
      par_o <= ^word_o[21:0] ^ cor_q;
    end
  end
endmodule
`default_nettype wire

/* verif/ca_parity_check_and_clock_gate_bench.sv */
/*
  Self-checking bench for the parity checker and clock gate.
  Assumes the controller model and an 8 ns mclk.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module ca_parity_check_and_clock_gate_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic cor = 1'b0;
  logic qn = 1'b1;
  logic sup = 1'b1;
  logic dis = 1'b0;
  logic [25:0] w = 26'h3c00000;
  logic ck_p, ck_n, par, rise_s, eo, eoe, fp, fn, foe, pon, pby;
  logic [25:0] word;
  logic [3:0] bp, bn, boe;
  wire logic err_n;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 32'h8a4c;
  int hold = 0;
  logic [3:0] s = 4'h0;
  logic pend = 1'b0;
  always #4 mclk = ~mclk;
  // Pull-up on the open-drain line
  assign err_n = eoe ? 1'b1 : eo;
  ca_controller_model ctl_u (.mclk(mclk), .rst(rst), .go(go), .err_n(err_n),
    .cor(cor), .w(w), .ck_p(ck_p), .ck_n(ck_n), .word_o(word), .par_o(par),
    .rise_s(rise_s));
  ca_parity_check_and_clock_gate dut_u (.mclk(mclk), .rst(rst), .ck_p(ck_p),
    .ck_n(ck_n), .row_col_addr_in(word[15:0]), .bank_addr_in(word[18:16]),
    .row_strobe_in(word[21]), .column_strobe_in(word[20]),
    .write_strobe_in(word[19]), .parity_bit_in(par),
    .chip_select_in_quad(word[25:22]), .quad_cs_enable_n(qn),
    .pll_analog_supply(sup), .clock_out_disable(dis),
    .parity_error_n_out(eo), .parity_error_n_oe_n(eoe),
    .buffered_clock_out_p(bp), .buffered_clock_out_n(bn),
    .buffered_clock_oe_n(boe), .feedback_clock_out_p(fp),
    .feedback_clock_out_n(fn), .feedback_clock_oe_n(foe), .pll_on_q(pon),
    .pll_bypass_q(pby));
  task automatic test_done;
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One link cycle; m: 0 random, 1 all fail, 2 all pass
  task automatic cyc(input logic q, input int m);
    int r;
    logic c;
    logic lo;
    logic [3:0] cs;
    @(posedge mclk);
    while (rise_s !== 1'b1) @(posedge mclk);
    s = {s[2:0], pend};
    lo = 1'b0;
    // Results landing during the low time are dropped
    if (hold == 2) begin
      lo = 1'b1;
      hold = 1;
    end else if (hold == 1) hold = 0;
    else if (s[3]) begin
      lo = 1'b1;
      hold = 2;
    end
    repeat (6) @(posedge mclk);
    `CHK(err_n, !lo)
    `CHK(foe, 1'b0)
    `CHK(fp, 1'b1)
    `CHK(fn, 1'b0)
    `CHK(boe, dis ? 4'hf : 4'h0)
    if (!dis) `CHK(bp, 4'hf)
    if (!dis) `CHK(bn, 4'h0)
    `CHK(pon, sup)
    `CHK(pby, !sup)
    r = $unsigned($random(seed)) % (q ? 3 : 5);
    if (m == 1) r = 0;
    cs = ~(4'h1 << r);
    if (q) cs[3:2] = 2'($random(seed));
    c = m == 1 || (m == 0 && $random(seed) % 4 == 0);
    pend = c && (q ? cs[1:0] != 2'h3 : cs != 4'hf);
    cor <= c;
    qn <= q;
    w <= {cs, 22'($random(seed))};
    dis <= 1'($random(seed));
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    `CHK(eoe, 1'b1)
    `CHK(boe, 4'hf)
    `CHK(pon, 1'b0)
    rst <= 1'b0;
    go <= 1'b1;
    repeat (8) cyc(1'b1, 2);
    repeat (60) cyc(1'b1, 0);
    $display("test 1 done");
    repeat (60) cyc(1'b0, 0);
    $display("test 2 done");
    repeat (8) cyc(1'b0, 1);
    $display("test 3 done");
    // Reset in mid-run while the error line is busy
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(eoe, 1'b1)
    `CHK(foe, 1'b1)
    rst <= 1'b0;
    s = 4'h0;
    hold = 0;
    pend = 1'b0;
    sup <= 1'b0;
    repeat (20) cyc(1'b1, 0);
    sup <= 1'b1;
    $display("test 4 done");
    repeat (4) cyc(1'b1, 2);
    go <= 1'b0;
    repeat (48) @(posedge mclk);
    `CHK(eoe, 1'b1)
    `CHK(boe, 4'hf)
    `CHK(foe, 1'b1)
    `CHK(pon, 1'b0)
    // Standby flushes the pipeline
    s = 4'h0;
    hold = 0;
    go <= 1'b1;
    repeat (20) cyc(1'b1, 0);
    $display("test 5 done");
    test_done;
  end
  initial begin
    #160000;
    n_errors++;
    test_done;
  end
endmodule
`default_nettype wire
